// ### pbm_mgmt_regs.v
`timescale 1ns/1ps
`include "pbm_defs.vh"

module pbm_mgmt_regs (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Serial management pins
    input wire mdc,
    input wire mdioIn,
    output reg mdioOut,
    output reg mdioOe,
    // Configuration straps
    input wire [4:0] phyAddrStrap,
    input wire speedStrap,
    input wire anEnableStrap,
    input wire duplexStrap,
    // Live conditions from the transceiver core
    input wire anComplete,
    input wire remoteFault,
    input wire linkUp,
    input wire jabber,
    // Controls to the transceiver core
    output reg softReset,
    output reg loopbackEn,
    output reg anEnable,
    output reg anRestart,
    output reg forcedSpeed100,
    output reg forcedFullDuplex,
    output reg powerDown,
    output reg isolate,
    output reg collisionTest
);

    localparam ST_IDLE = 4'b0001;
    localparam ST_HDR = 4'b0010;
    localparam ST_TURN = 4'b0100;
    localparam ST_DATA = 4'b1000;

    // Synchronisers
    reg mdcS1_r, mdcS2_r, mdcS3_r;
    reg mdioS1_r, mdioS2_r;
    reg [7:0] strapS1_r, strapS2_r;
    reg [1:0] strapCnt_r;
    reg [4:0] phyAddr_r;

    // Frame engine
    reg [3:0] state_r;
    reg [5:0] preCnt_r;
    reg [4:0] bitCnt_r;
    reg [13:0] hdr_r;
    reg [15:0] shift_r;
    reg [15:0] rdData_r;
    reg active_r;

    // Register state
    reg loop_r, speed_r, anEn_r, pdown_r, iso_r, anRst_r, duplex_r, col_r;
    reg [15:0] idHi_r;
    reg [15:0] store_r [0:31];
    reg rfLat_r, linkLat_r, jabLat_r;
    reg [4:0] srstCnt_r;

    // Clock rise and data bit pass equal-depth synchronisers, so they align
    wire mdcRise = mdcS2_r & ~mdcS3_r;
    wire bitIn = mdioS2_r;
    wire [13:0] hdrNow = {hdr_r[12:0], bitIn};
    wire [1:0] opNow = hdrNow[11:10];
    wire [4:0] padNow = hdrNow[9:5];
    wire [4:0] regNow = hdrNow[4:0];
    wire [4:0] wrIdx = hdr_r[4:0];
    wire [15:0] wrData = {shift_r[14:0], bitIn};
    wire srstBusy = (srstCnt_r != 5'h00);

    // Read of the status register at the end of the header; write hit at the last data bit
    wire hdrEnd = mdcRise && state_r == ST_HDR &&
        bitCnt_r == `PBM_BIT_HDR_END;
    wire rdHit = hdrEnd && opNow == `PBM_OP_READ && padNow == phyAddr_r;
    wire stsRd = rdHit && regNow == `PBM_IDX_STAT;
    wire wrHit = mdcRise && state_r == ST_DATA && active_r &&
        bitCnt_r == `PBM_BIT_LAST && hdr_r[11:10] == `PBM_OP_WRITE;

    wire [15:0] ctrlWord = {srstBusy, loop_r, speed_r, anEn_r, pdown_r,
        iso_r, anRst_r, duplex_r, col_r, 7'h00};
    wire [15:0] statWord = {1'b0, 4'hF, 5'h00, anComplete, rfLat_r, 1'b1,
        linkLat_r, jabLat_r, 1'b1};

    function mapped;
        input [4:0] idx;
        begin
            case (idx)
                `PBM_IDX_IDLO, `PBM_IDX_ADV, `PBM_IDX_LPA, `PBM_IDX_EXP,
                `PBM_IDX_MODE, `PBM_IDX_SPEC, `PBM_IDX_SYMERR,
                `PBM_IDX_CSI, `PBM_IDX_ISRC, `PBM_IDX_IMSK,
                `PBM_IDX_PSCS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    // Read word taken at the last header bit, before any latch clears
    reg [15:0] rdMux;
    always @* begin
        case (regNow)
            `PBM_IDX_CTRL: rdMux = ctrlWord;
            `PBM_IDX_STAT: rdMux = statWord;
            `PBM_IDX_IDHI: rdMux = idHi_r;
            default: rdMux = mapped(regNow) ? store_r[regNow] : 16'h0000;
        endcase
    end

    // Pin and strap synchronisers
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mdcS1_r <= 1'b0;
            mdcS2_r <= 1'b0;
            mdcS3_r <= 1'b0;
            mdioS1_r <= 1'b1;
            mdioS2_r <= 1'b1;
            strapS1_r <= 8'h00;
            strapS2_r <= 8'h00;
        end else begin
            mdcS1_r <= mdc;
            mdcS2_r <= mdcS1_r;
            mdcS3_r <= mdcS2_r;
            mdioS1_r <= mdioIn;
            mdioS2_r <= mdioS1_r;
            strapS1_r <= {phyAddrStrap, speedStrap, anEnableStrap,
                duplexStrap};
            strapS2_r <= strapS1_r;
        end
    end

    // Frame engine
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            preCnt_r <= 6'h00;
            bitCnt_r <= 5'h00;
            hdr_r <= 14'h0000;
            shift_r <= 16'h0000;
            rdData_r <= 16'h0000;
            active_r <= 1'b0;
            mdioOut <= 1'b1;
            mdioOe <= 1'b0;
        end else if (mdcRise) begin
            case (state_r)
                ST_IDLE: begin
                    mdioOe <= 1'b0;
                    if (bitIn) begin
                        if (preCnt_r != `PBM_PRE_LEN) begin
                            preCnt_r <= preCnt_r + 6'h01;
                        end
                    end else begin
                        if (preCnt_r == `PBM_PRE_LEN) begin
                            state_r <= ST_HDR;
                            bitCnt_r <= 5'h01;
                            hdr_r <= 14'h0000;
                        end
                        preCnt_r <= 6'h00;
                    end
                end
                ST_HDR: begin
                    hdr_r <= hdrNow;
                    bitCnt_r <= bitCnt_r + 5'h01;
                    if (bitCnt_r == 5'h01 && !bitIn) begin
                        state_r <= ST_IDLE;
                    end else if (bitCnt_r == `PBM_BIT_OP_END &&
                        hdrNow[1:0] != `PBM_OP_READ &&
                        hdrNow[1:0] != `PBM_OP_WRITE) begin
                        state_r <= ST_IDLE;
                    end else if (bitCnt_r == `PBM_BIT_HDR_END) begin
                        state_r <= ST_TURN;
                        active_r <= (padNow == phyAddr_r);
                        rdData_r <= rdMux;
                    end
                end
                ST_TURN: begin
                    // First turnaround bit drives zero, second the data MSB
                    bitCnt_r <= bitCnt_r + 5'h01;
                    if (bitCnt_r == `PBM_BIT_TA1) begin
                        if (active_r && hdr_r[11:10] == `PBM_OP_READ) begin
                            mdioOe <= 1'b1;
                            mdioOut <= 1'b0;
                        end
                    end else begin
                        state_r <= ST_DATA;
                        mdioOut <= rdData_r[15];
                        rdData_r <= {rdData_r[14:0], 1'b0};
                    end
                end
                ST_DATA: begin
                    shift_r <= wrData;
                    bitCnt_r <= bitCnt_r + 5'h01;
                    mdioOut <= rdData_r[15];
                    rdData_r <= {rdData_r[14:0], 1'b0};
                    if (bitCnt_r == `PBM_BIT_LAST) begin
                        state_r <= ST_IDLE;
                        mdioOe <= 1'b0;
                        mdioOut <= 1'b1;
                        active_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    mdioOe <= 1'b0;
                end
            endcase
        end
    end

    // Status latches; a new event wins over the clear of a read
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rfLat_r <= 1'b0;
            jabLat_r <= 1'b0;
            linkLat_r <= 1'b0;
        end else begin
            rfLat_r <= remoteFault | (rfLat_r & ~stsRd);
            jabLat_r <= jabber | (jabLat_r & ~stsRd);
            linkLat_r <= linkUp & (linkLat_r | stsRd);
        end
    end

    // Registers, straps and soft reset
    integer i;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strapCnt_r <= 2'h0;
            phyAddr_r <= 5'h00;
            loop_r <= 1'b0;
            speed_r <= 1'b0;
            anEn_r <= 1'b0;
            pdown_r <= 1'b0;
            iso_r <= 1'b0;
            anRst_r <= 1'b0;
            duplex_r <= 1'b0;
            col_r <= 1'b0;
            idHi_r <= `PBM_IDHI_RST;
            srstCnt_r <= 5'h00;
            for (i = 0; i < 32; i = i + 1) begin
                store_r[i] <= 16'h0000;
            end
        end else begin
            anRst_r <= 1'b0;
            if (strapCnt_r != 2'h3) begin
                strapCnt_r <= strapCnt_r + 2'h1;
            end
            if (strapCnt_r == `PBM_STRAP_CYC) begin
                phyAddr_r <= strapS2_r[7:3];
                speed_r <= strapS2_r[2];
                anEn_r <= strapS2_r[1];
                duplex_r <= strapS2_r[0];
            end
            if (srstBusy) begin
                srstCnt_r <= srstCnt_r - 5'h01;
            end
            if (wrHit) begin
                case (wrIdx)
                    `PBM_IDX_CTRL: begin
                        if (wrData[`PBM_CTRL_SRST]) begin
                            // Config bits kept, straps not resampled
                            srstCnt_r <= `PBM_SRST_CYC;
                            loop_r <= 1'b0;
                            pdown_r <= 1'b0;
                            iso_r <= 1'b0;
                            col_r <= 1'b0;
                        end else begin
                            loop_r <= wrData[`PBM_CTRL_LOOP];
                            speed_r <= wrData[`PBM_CTRL_SPEED];
                            anEn_r <= wrData[`PBM_CTRL_ANEN];
                            pdown_r <= wrData[`PBM_CTRL_PDOWN];
                            iso_r <= wrData[`PBM_CTRL_ISO];
                            anRst_r <= wrData[`PBM_CTRL_ANRST];
                            duplex_r <= wrData[`PBM_CTRL_DUPLEX];
                            col_r <= wrData[`PBM_CTRL_COLTEST];
                        end
                    end
                    `PBM_IDX_IDHI: idHi_r <= wrData;
                    default: begin
                        if (mapped(wrIdx)) begin
                            store_r[wrIdx] <= wrData;
                        end
                    end
                endcase
            end
        end
    end

    // Control outputs
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            softReset <= 1'b0;
            loopbackEn <= 1'b0;
            anEnable <= 1'b0;
            anRestart <= 1'b0;
            forcedSpeed100 <= 1'b0;
            forcedFullDuplex <= 1'b0;
            powerDown <= 1'b0;
            isolate <= 1'b0;
            collisionTest <= 1'b0;
        end else begin
            softReset <= srstBusy;
            loopbackEn <= loop_r;
            anEnable <= anEn_r;
            anRestart <= anRst_r;
            // Forced speed and duplex are masked while negotiation runs
            forcedSpeed100 <= speed_r & ~anEn_r;
            forcedFullDuplex <= duplex_r & ~anEn_r;
            powerDown <= pdown_r;
            isolate <= iso_r;
            collisionTest <= col_r;
        end
    end

endmodule // pbm_mgmt_regs

// ### pbm_defs.vh
`ifndef PBM_DEFS_VH
`define PBM_DEFS_VH

// Register indices
`define PBM_IDX_CTRL 5'h00
`define PBM_IDX_STAT 5'h01
`define PBM_IDX_IDHI 5'h02
`define PBM_IDX_IDLO 5'h03
`define PBM_IDX_ADV 5'h04
`define PBM_IDX_LPA 5'h05
`define PBM_IDX_EXP 5'h06
`define PBM_IDX_MODE 5'h11
`define PBM_IDX_SPEC 5'h12
`define PBM_IDX_SYMERR 5'h1A
`define PBM_IDX_CSI 5'h1B
`define PBM_IDX_ISRC 5'h1D
`define PBM_IDX_IMSK 5'h1E
`define PBM_IDX_PSCS 5'h1F

// Control register fields
`define PBM_CTRL_SRST 15
`define PBM_CTRL_LOOP 14
`define PBM_CTRL_SPEED 13
`define PBM_CTRL_ANEN 12
`define PBM_CTRL_PDOWN 11
`define PBM_CTRL_ISO 10
`define PBM_CTRL_ANRST 9
`define PBM_CTRL_DUPLEX 8
`define PBM_CTRL_COLTEST 7

// Status register fields
`define PBM_STAT_ABILITY 5'h0F
`define PBM_STAT_ANDONE 5
`define PBM_STAT_RFAULT 4
`define PBM_STAT_ANABLE 3
`define PBM_STAT_LINK 2
`define PBM_STAT_JABBER 1
`define PBM_STAT_EXTCAP 0

// Identifier reset value, arbitrary
`define PBM_IDHI_RST 16'h5A3C

// Management frame layout, bit counts after the preamble
`define PBM_PRE_LEN 6'h20
`define PBM_BIT_OP_END 5'h03
`define PBM_BIT_HDR_END 5'h0D
`define PBM_BIT_TA1 5'h0E
`define PBM_BIT_LAST 5'h1F
`define PBM_OP_READ 2'h2
`define PBM_OP_WRITE 2'h1

// Soft reset duration, 100 ns of the 5 ns core clock
`define PBM_SRST_CYC 5'h14

// Cycle at which synchronised straps are caught after reset release
`define PBM_STRAP_CYC 2'h2

`endif

// ### pbm_mgmt_regs_props.sv
`timescale 1ns/1ps
module pbm_mgmt_regs_props (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Management pins
    input wire mdc,
    input wire mdioOut,
    input wire mdioOe,
    // Core controls
    input wire softReset,
    input wire loopbackEn,
    input wire anEnable,
    input wire anRestart,
    input wire forcedSpeed100,
    input wire forcedFullDuplex,
    input wire powerDown,
    input wire isolate,
    input wire collisionTest
);
    logic [4:0] srCnt_r;
    logic [4:0] oeRise_r;
    logic mdcPrev_r;

    // Soft reset length and management clock rises while driving
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            srCnt_r <= 5'h0;
            oeRise_r <= 5'h0;
            mdcPrev_r <= 1'b0;
        end else begin
            srCnt_r <= softReset ? srCnt_r + 5'h1 : 5'h0;
            mdcPrev_r <= mdc;
            if (!mdioOe)
                oeRise_r <= 5'h0;
            else if (mdc && !mdcPrev_r)
                oeRise_r <= oeRise_r + 5'h1;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_speed_gated:
        assert property (anEnable |-> !forcedSpeed100)
        else $error("Forced speed while negotiating");
    a_duplex_gated:
        assert property (anEnable |-> !forcedFullDuplex)
        else $error("Forced duplex while negotiating");
    a_restart_pulse:
        assert property (anRestart |=> !anRestart)
        else $error("Restart longer than one cycle");
    a_srst_length:
        assert property ($fell(softReset) |-> srCnt_r == 5'h14)
        else $error("Soft reset length wrong");
    a_srst_short:
        assert property (softReset |-> srCnt_r < 5'h14)
        else $error("Soft reset too long");
    a_srst_clears:
        assert property ($rose(softReset) |-> ##[1:3]
            !(loopbackEn || powerDown || isolate || collisionTest))
        else $error("Soft reset left modes set");
    a_srst_keeps:
        assert property (softReset |=> $stable(anEnable)
            && $stable(forcedSpeed100) && $stable(forcedFullDuplex))
        else $error("Soft reset changed config");
    a_read_span:
        assert property ($fell(mdioOe) |-> oeRise_r == 5'h11)
        else $error("Read drive span wrong");
    a_drive_late:
        assert property (mdioOe && $changed(mdioOut) |->
            $past(mdc, 2) && mdc)
        else $error("Read bit changed off clock");
endmodule // pbm_mgmt_regs_props

bind pbm_mgmt_regs pbm_mgmt_regs_props u_props (.core_clk(core_clk),
    .reset_n(reset_n), .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .softReset(softReset), .loopbackEn(loopbackEn), .anEnable(anEnable),
    .anRestart(anRestart), .forcedSpeed100(forcedSpeed100),
    .forcedFullDuplex(forcedFullDuplex), .powerDown(powerDown),
    .isolate(isolate), .collisionTest(collisionTest));

// ### pbm_mgr_model.sv
`timescale 1ns/1ps
module pbm_mgr_model (
    // Clock
    input wire core_clk,
    // Management pins
    input wire mdioWire,
    output logic mdc,
    output logic mgrOe,
    output logic mgrOut
);
    initial begin
        mdc = 1'b0;
        mgrOe = 1'b0;
        mgrOut = 1'b1;
    end

    // One bit: drive while clock low, sample at the rise, 65 ns period
    task automatic slot(input logic oe, input logic v, output logic s);
        mgrOe <= oe;
        mgrOut <= v;
        repeat (6) @(posedge core_clk);
        s = mdioWire;
        mdc <= 1'b1;
        repeat (7) @(posedge core_clk);
        mdc <= 1'b0;
    endtask

    // Full frame, fresh preamble each time; clock stands still after
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] idx, input logic [15:0] wd,
        output logic [15:0] rd);
        logic [13:0] hdr;
        logic s;
        hdr = {2'b01, op, phy, idx};
        @(posedge core_clk);
        for (int i = 0; i < 32; i++)
            slot(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--)
            slot(1'b1, hdr[i], s);
        slot(op == 2'b01, 1'b1, s);
        slot(op == 2'b01, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            slot(op == 2'b01, wd[i], s);
            rd[i] = s;
        end
        mgrOe <= 1'b0;
    endtask
endmodule // pbm_mgr_model

// ### testbench.sv
`timescale 1ns/1ps
`include "pbm_defs.vh"
module testbench;
    logic core_clk, reset_n, mdc, mdioOut, mdioOe, mgrOe, mgrOut;
    logic speedStrap, anEnableStrap, duplexStrap, softReset, anRestart;
    logic anComplete, remoteFault, linkUp, jabber, loopbackEn, anEnable;
    logic forcedSpeed100, forcedFullDuplex, powerDown, isolate;
    logic collisionTest;
    logic [15:0] rd;
    int err_total = 0, n_tests = 0, cyc = 0, pulses = 0, srHigh = 0;
    // Pull-up holds the line high when nobody drives
    wire mdioWire = mdioOe ? mdioOut : (mgrOe ? mgrOut : 1'b1);

    pbm_mgmt_regs DUT (.core_clk(core_clk), .reset_n(reset_n),
        .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe),
        .phyAddrStrap(5'h05), .speedStrap(speedStrap),
        .anEnableStrap(anEnableStrap), .duplexStrap(duplexStrap),
        .anComplete(anComplete), .remoteFault(remoteFault),
        .linkUp(linkUp), .jabber(jabber), .softReset(softReset),
        .loopbackEn(loopbackEn), .anEnable(anEnable),
        .anRestart(anRestart), .forcedSpeed100(forcedSpeed100),
        .forcedFullDuplex(forcedFullDuplex), .powerDown(powerDown),
        .isolate(isolate), .collisionTest(collisionTest));
    pbm_mgr_model mgr (.core_clk(core_clk), .mdioWire(mdioWire),
        .mdc(mdc), .mgrOe(mgrOe), .mgrOut(mgrOut));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        pulses <= pulses + anRestart;
        srHigh <= srHigh + softReset;
        if (cyc == 80000) begin
            $display("Timeout reached");
            err_total++;
            report_and_stop();
        end
    end

    task automatic check(input string nm, input logic [15:0] exp,
        input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        mgr.frame(`PBM_OP_WRITE, 5'h05, idx, d, rd);
        repeat (8) @(posedge core_clk);
    endtask
    task automatic rdr(input logic [4:0] idx, input logic [15:0] exp,
        input string nm);
        mgr.frame(`PBM_OP_READ, 5'h05, idx, 16'h0000, rd);
        check(nm, exp, rd);
    endtask

    task automatic t_reset();
        rdr(`PBM_IDX_CTRL, 16'h2100, "ctrl reset");
        check("speed out", 16'h0001, forcedSpeed100);
        rdr(`PBM_IDX_STAT, 16'h7809, "status first");
        rdr(`PBM_IDX_STAT, 16'h780D, "status idle");
        rdr(`PBM_IDX_IDHI, `PBM_IDHI_RST, "id reset");
        $display("t_reset done");
    endtask

    task automatic t_map();
        logic [4:0] ix [12];
        ix = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h11, 5'h12, 5'h1A,
            5'h1B, 5'h1D, 5'h1E, 5'h1F};
        foreach (ix[i]) begin
            wr(ix[i], {11'h5A5, ix[i]});
            rdr(ix[i], {11'h5A5, ix[i]}, "map");
        end
        wr(5'h07, 16'hFFFF);
        rdr(5'h07, 16'h0000, "unmapped");
        mgr.frame(`PBM_OP_WRITE, 5'h06, 5'h03, 16'h0000, rd);
        mgr.frame(`PBM_OP_READ, 5'h06, 5'h03, 16'h0000, rd);
        check("other phy", 16'hFFFF, rd);
        rdr(5'h03, 16'hB4A3, "other phy write");
        mgr.frame(2'h3, 5'h05, 5'h03, 16'h0000, rd);
        rdr(5'h03, 16'hB4A3, "bad op");
        $display("t_map done");
    endtask

    task automatic t_ctrl();
        wr(`PBM_IDX_CTRL, 16'h217F);
        rdr(`PBM_IDX_CTRL, 16'h2100, "reserved ctrl");
        wr(`PBM_IDX_CTRL, 16'h3100);
        check("neg gates", 16'h0400, {anEnable, forcedSpeed100,
            forcedFullDuplex, 8'h00});
        wr(`PBM_IDX_CTRL, 16'h1200);
        rdr(`PBM_IDX_CTRL, 16'h1000, "restart clear");
        check("restart pulses", 16'h0001, pulses);
        wr(`PBM_IDX_CTRL, 16'h0000);
        wr(`PBM_IDX_CTRL, 16'h0800);
        check("power down", 16'h0001, powerDown);
        wr(`PBM_IDX_CTRL, 16'h6580);
        check("modes", 16'h001F, {powerDown, isolate, loopbackEn,
            collisionTest, forcedSpeed100, forcedFullDuplex});
        rdr(`PBM_IDX_CTRL, 16'h6580, "modes read");
        $display("t_ctrl done");
    endtask

    task automatic t_srst();
        speedStrap <= 1'b0;
        anEnableStrap <= 1'b1;
        duplexStrap <= 1'b0;
        wr(`PBM_IDX_CTRL, 16'h8000);
        repeat (30) @(posedge core_clk);
        check("srst cycles", 16'h0014, srHigh);
        rdr(`PBM_IDX_CTRL, 16'h2100, "after srst");
        check("loop cleared", 16'h0000, loopbackEn);
        $display("t_srst done");
    endtask

    task automatic t_latch();
        anComplete <= 1'b1;
        remoteFault <= 1'b1;
        jabber <= 1'b1;
        linkUp <= 1'b0;
        @(posedge core_clk);
        remoteFault <= 1'b0;
        linkUp <= 1'b1;
        rdr(`PBM_IDX_STAT, 16'h783B, "latched");
        wr(`PBM_IDX_STAT, 16'h0000);
        rdr(`PBM_IDX_STAT, 16'h782F, "released");
        jabber <= 1'b0;
        rdr(`PBM_IDX_STAT, 16'h782F, "jabber held");
        rdr(`PBM_IDX_STAT, 16'h782D, "jabber gone");
        $display("t_latch done");
    endtask

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        speedStrap = 1'b1;
        anEnableStrap = 1'b0;
        duplexStrap = 1'b1;
        anComplete = 1'b0;
        remoteFault = 1'b0;
        linkUp = 1'b1;
        jabber = 1'b0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_reset();
        t_map();
        t_ctrl();
        t_srst();
        t_latch();
        report_and_stop();
    end
endmodule // testbench
